// File: verification/flrb_bus_master.sv
// Two-wire bus master model that drives clock and data toward the slave
`timescale 1ns/100ps
module flrb_bus_master #(
    parameter int HI_NS = 600, // Clock high time, the read data margin
    parameter int LO_NS = 200  // Clock low time, above the start spacing
) (
    output logic      scl,     // Serial clock
    output logic      sda_low, // High pulls the data line low
    input  wire logic sda_in   // Resolved data level
);
    // Bus idles released; the pull-up then holds data high
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // Start or repeated start: data falls while the clock is high
    task automatic start_cond;
        sda_low = 1'b0;
        #(LO_NS / 2);
        scl = 1'b1;
        #(HI_NS);
        sda_low = 1'b1;
        #(HI_NS);
        scl = 1'b0;
        #(LO_NS / 2);
    endtask : start_cond

    // Stop: data rises while the clock is high
    task automatic stop_cond;
        sda_low = 1'b1;
        #(LO_NS / 2);
        scl = 1'b1;
        #(HI_NS);
        sda_low = 1'b0;
        #(HI_NS);
    endtask : stop_cond

    // One clock pulse; data only changes while the clock is low
    task automatic clk_bit(input logic b, output logic s);
        sda_low = ~b;
        #(LO_NS / 2);
        scl = 1'b1;
        #(HI_NS);
        s = sda_in;
        scl = 1'b0;
        #(LO_NS / 2);
    endtask : clk_bit

    // Eight bits MSB first, then a released ninth pulse for the ack
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
        clk_bit(1'b1, s);
        ack = ~s;
    endtask : send_byte

    // Receive eight bits, then ack low or leave released on the last one
    task automatic recv_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
        clk_bit(last, s);
    endtask : recv_byte
endmodule : flrb_bus_master

// File: verification/tb.sv
// Self-checking bench for the flash LED serial register bank
`timescale 1ns/100ps
module tb;
    import flrb_pkg::*;
    localparam int STEP  = 4;      // Short timeout step keeps flash brief
    localparam int LIMIT = 100000; // Cycle ceiling above the full run
    localparam logic [7:0] OFS [10] = '{8'h10, 8'h12, 8'h20, 8'h80, 8'ha0,
                                        8'hb0, 8'hc0, 8'hd0, 8'he0, 8'hf0};
    localparam logic [7:0] RST [10] = '{8'hf8, 8'hf8, 8'h80, 8'hf8, 8'hfa,
                                        8'hfd, 8'hef, 8'h00, 8'h6a, 8'hf0};
    logic       CLK, RESET, trig, mpp1_i, mpp2_i, tsd, ledf, therm, suplow;
    logic       ack;
    logic [7:0] v;
    wire logic  scl, sda_low, sda_oe, mpp1_o, mpp1_oe, mpp2_o, mpp2_oe;
    wire logic  flash_on, sup_en;
    wire logic [1:0] led_mode, sup_th;
    wire logic [2:0] ind_code, torch_code;
    wire logic [3:0] flash_code;
    wire logic  sda = ~(sda_low | sda_oe); // Open drain with pull-up
    int         bad_count = 0, n_checks = 0, cyc = 0;

    flrb_reg_bank #(.TO_STEP_CYC(STEP)) i_flrb_reg_bank (
        .CLK(CLK), .RESET(RESET), .SCL(scl), .SDA_I(sda), .SDA_O(),
        .SDA_OE(sda_oe), .FLASH_TRIG(trig), .FIRST_MPP_I(mpp1_i),
        .FIRST_MPP_O(mpp1_o), .FIRST_MPP_OE(mpp1_oe),
        .SECOND_MPP_I(mpp2_i), .SECOND_MPP_O(mpp2_o),
        .SECOND_MPP_OE(mpp2_oe), .THERMAL_SD(tsd), .LED_FAULT(ledf),
        .LED_THERMAL_FLAG_IN(therm), .SUPPLY_LOW(suplow),
        .LED_MODE(led_mode), .FLASH_ON(flash_on), .IND_CODE(ind_code),
        .TORCH_CODE(torch_code), .FLASH_CODE(flash_code),
        .SUP_MON_EN(sup_en), .SUP_TH(sup_th));
    flrb_bus_master i_flrb_bus_master (.scl(scl), .sda_low(sda_low),
                                       .sda_in(sda));

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : summarize

    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Inputs change one nanosecond after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask : tick

    // Write: address, offset, data; margin lets the register settle
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        logic [2:0] a;
        i_flrb_bus_master.start_cond();
        i_flrb_bus_master.send_byte(8'ha6, a[2]);
        i_flrb_bus_master.send_byte(ofs, a[1]);
        i_flrb_bus_master.send_byte(d, a[0]);
        i_flrb_bus_master.stop_cond();
        chk("write acks", {5'h0, a}, 8'h07);
        tick(8);
    endtask : wr

    // Read: offset set, repeated start, one byte ended by a nack
    task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
        logic [2:0] a;
        i_flrb_bus_master.start_cond();
        i_flrb_bus_master.send_byte(8'ha6, a[2]);
        i_flrb_bus_master.send_byte(ofs, a[1]);
        i_flrb_bus_master.start_cond();
        i_flrb_bus_master.send_byte(8'ha7, a[0]);
        i_flrb_bus_master.recv_byte(1'b1, d);
        i_flrb_bus_master.stop_cond();
        chk("read acks", {5'h0, a}, 8'h07);
    endtask : rd

    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    // A hang counts as a mismatch and ends the run
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            bad_count++;
            summarize();
        end
    end

    initial begin
        {RESET, trig, mpp1_i, mpp2_i, tsd, ledf, therm, suplow} = 8'h80;
        tick(5);
        RESET = 1'b0;
        tick(6);
        // Defaults of the whole table and of the decoded fields
        for (int i = 0; i < 10; i++) begin
            rd(OFS[i], v);
            chk("reset value", v, RST[i]);
        end
        chk("mode fields", {led_mode, ind_code, torch_code}, 8'h02);
        chk("flash fields", {flash_code, sup_en, sup_th, flash_on}, 8'hd0);
        chk("pin enables", {6'h0, mpp1_oe, mpp2_oe}, 8'h00);
        rd(8'h11, v);
        chk("unmapped read", v, 8'h00);
        // A foreign address must go unanswered
        i_flrb_bus_master.start_cond();
        i_flrb_bus_master.send_byte(8'ha8, ack);
        i_flrb_bus_master.stop_cond();
        chk("foreign ack", {7'h0, ack}, 8'h00);
        tick(1);
        for (int i = 1; i < 4; i++) begin
            wr(8'h10, 8'(i % 3));
            chk("mode code", {6'h0, led_mode}, 8'(i % 3));
        end
        wr(8'h12, 8'hff);
        chk("indicator code", {5'h0, ind_code}, 8'h07);
        wr(8'h80, 8'h03);
        chk("monitor fields", {5'h0, sup_th, sup_en}, 8'h03);
        wr(8'h80, 8'h06);
        chk("monitor fields", {5'h0, sup_th, sup_en}, 8'h06);
        wr(8'h20, 8'h3f);
        chk("pin drive", {4'h0, mpp1_oe, mpp1_o, mpp2_oe, mpp2_o}, 8'h0f);
        mpp1_i = 1'b1;
        wr(8'h20, 8'h09);
        chk("pin release", {6'h0, mpp1_oe, mpp2_oe}, 8'h00);
        rd(8'h20, v);
        chk("pin levels", v & 8'h24, 8'h04);
        // LED thermal and supply faults pull the interrupt pin, the flag read clears them
        wr(8'h80, 8'h01);
        wr(8'h20, 8'h58);
        chk("int idle", {7'h0, mpp2_oe}, 8'h00);
        {tsd, ledf, therm, suplow} = 4'hf;
        tick(8);
        chk("int active", {6'h0, mpp2_oe, mpp2_o}, 8'h02);
        {tsd, ledf, therm, suplow} = 4'h0;
        wr(8'hd0, 8'hff);
        rd(8'hd0, v);
        chk("flags", v, 8'ha6);
        rd(8'hd0, v);
        chk("flags cleared", v, 8'h00);
        chk("int cleared", {7'h0, mpp2_oe}, 8'h00);
        // Level trigger ends early on the falling input, long timeout
        wr(8'hc0, 8'h1f);
        wr(8'h10, 8'h02);
        trig = 1'b1;
        tick(6);
        chk("level on", {5'h0, flash_on, led_mode}, 8'h06);
        trig = 1'b0;
        tick(8);
        chk("level end", {5'h0, flash_on, led_mode}, 8'h00);
        rd(8'hd0, v);
        chk("no timeout", v, 8'h00);
        // Edge trigger holds on past the input until the timeout
        wr(8'hc0, 8'h02);
        wr(8'h10, 8'h06);
        trig = 1'b1;
        tick(6);
        chk("edge on", {5'h0, flash_on, led_mode}, 8'h06);
        trig = 1'b0;
        tick(4);
        chk("edge held", {5'h0, flash_on, led_mode}, 8'h06);
        tick(20);
        chk("edge end", {5'h0, flash_on, led_mode}, 8'h00);
        rd(8'hd0, v);
        chk("timeout flag", v, 8'h01);
        summarize();
    end
endmodule : tb

// File: verilog/flrb_defines.svh
// Constants for the flash LED serial register bank
`ifndef FLRB_DEFINES_SVH
`define FLRB_DEFINES_SVH
`define FLRB_DEV_ADDR    7'h53
`define FLRB_ACK_SLOT    4'h8
`define FLRB_OFS_MODE    8'h10
`define FLRB_OFS_IND     8'h12
`define FLRB_OFS_PIN     8'h20
`define FLRB_OFS_SUP     8'h80
`define FLRB_OFS_TORCH   8'ha0
`define FLRB_OFS_FLASH   8'hb0
`define FLRB_OFS_TOUT    8'hc0
`define FLRB_OFS_FLAGS   8'hd0
`define FLRB_OFS_CFG1    8'he0
`define FLRB_OFS_CFG2    8'hf0
`define FLRB_RST_MODE    8'hf8
`define FLRB_RST_IND     8'hf8
`define FLRB_RST_PIN     8'h80
`define FLRB_RST_SUP     8'hf8
`define FLRB_RST_TORCH   8'hfa
`define FLRB_RST_FLASH   8'hfd
`define FLRB_RST_TOUT    8'hef
`define FLRB_RST_FLAGS   8'h00
`define FLRB_RST_CFG1    8'h6a
`define FLRB_RST_CFG2    8'hf0
`define FLRB_IX_MODE     4'h0
`define FLRB_IX_IND      4'h1
`define FLRB_IX_PIN      4'h2
`define FLRB_IX_SUP      4'h3
`define FLRB_IX_TORCH    4'h4
`define FLRB_IX_FLASH    4'h5
`define FLRB_IX_TOUT     4'h6
`define FLRB_IX_CFG1     4'h7
`define FLRB_IX_CFG2     4'h8
`define FLRB_IX_NONE     4'hf
`define FLRB_MODE_F      1:0
`define FLRB_MODE_OFF    2'h0
`define FLRB_TRIG_MODE   2
`define FLRB_CODE3_F     2:0
`define FLRB_CODE4_F     3:0
`define FLRB_TOUT_F      4:0
`define FLRB_P1_GPIO     0
`define FLRB_P1_DIR      1
`define FLRB_P1_DAT      2
`define FLRB_P2_GPIO     3
`define FLRB_P2_DIR      4
`define FLRB_P2_DAT      5
`define FLRB_P2_INT      6
`define FLRB_SUP_EN      0
`define FLRB_SUP_TH_F    2:1
`define FLRB_FL_TO       0
`define FLRB_FL_TSD      1
`define FLRB_FL_LEDF     2
`define FLRB_FL_THERM    5
`define FLRB_FL_SUP      7
`define FLRB_CLK_NS      10
`define FLRB_TO_STEP_NS  32000
`endif

// File: verilog/flrb_pkg.sv
// Types shared by the flash LED serial register bank
package flrb_pkg;
    typedef enum logic [1:0] {PH_ADDR, PH_REG, PH_DATA} flrb_phase_t;
    typedef enum logic {FL_IDLE, FL_ON} flrb_flash_t;
endpackage : flrb_pkg

// File: verilog/flrb_reg_bank.sv
// Serial slave, register bank and flash pulse control of the LED driver
//
// Notes on behaviour
// [R1] Each byte is eight bits, MSB first, followed by one acknowledge slot.
// [R2] The master clocks the ninth pulse and releases data during it, or pulls it low to ack a read byte.
// [R3] The device pulls data low in the ninth pulse of its own address and of each byte written to it.
// [R4] Reset loads every register default, such as 0xf8, 0x00 and 0x6a.
// [R5] Mode bits 1:0 select shutdown 00, indicator 01 or torch 10.
// [R6] The mode bits clear themselves whenever a flash pulse ends.
// [R7] Trigger mode 0 keeps flash on while the trigger is high or to timeout.
// [R8] Trigger mode 1 starts flash on a rising edge and ends it at timeout.
// [R9] Indicator bits 2:0 give a current code in 2.25 mA steps.
// [R10] Pin bits 0 and 3 make pin one or two an interrupt input or a GPIO.
// [R11] Bits 1 and 4 set GPIO direction, bits 2 and 5 carry the pin data.
// [R12] Supply monitor bit 0 switches the input comparator off or on.
// [R13] Supply monitor bits 2:1 choose one of four falling thresholds.
// [R14] Pin bit 6 with pin two a GPIO output pulls it low on the LED thermal or supply flag.
// [R15] The slave answers address 1010011, then register address, then data.
// [R16] Reading the fault flag register clears its flag bits.
`timescale 1ns/100ps
`include "flrb_defines.svh"
module flrb_reg_bank
    import flrb_pkg::*;
#(
    parameter int TO_STEP_CYC = `FLRB_TO_STEP_NS / `FLRB_CLK_NS
) (
    input  wire logic       CLK,         // System clock, 100 MHz
    input  wire logic       RESET,       // Synchronous reset, high
    input  wire logic       SCL,         // Serial clock from the master
    input  wire logic       SDA_I,       // Serial data level
    output wire logic       SDA_O,       // Serial data drive value
    output wire logic       SDA_OE,      // Serial data pulled low
    input  wire logic       FLASH_TRIG,  // Flash trigger pin
    input  wire logic       FIRST_MPP_I, // First multi purpose pin in
    output wire logic       FIRST_MPP_O, // First multi purpose pin out
    output wire logic       FIRST_MPP_OE, // First pin drive enable
    input  wire logic       SECOND_MPP_I, // Second multi purpose pin in
    output wire logic       SECOND_MPP_O, // Second pin out
    output wire logic       SECOND_MPP_OE, // Second pin drive enable
    input  wire logic       THERMAL_SD,  // Die over temperature
    input  wire logic       LED_FAULT,   // LED open or short
    input  wire logic       LED_THERMAL_FLAG_IN, // LED over temperature
    input  wire logic       SUPPLY_LOW,  // Input below threshold
    output wire logic [1:0] LED_MODE,    // Operating mode code
    output wire logic       FLASH_ON,    // Flash current active
    output wire logic [2:0] IND_CODE,    // Indicator current code
    output wire logic [2:0] TORCH_CODE,  // Torch current code
    output wire logic [3:0] FLASH_CODE,  // Flash current code
    output wire logic       SUP_MON_EN,  // Supply comparator on
    output wire logic [1:0] SUP_TH       // Supply threshold code
);
    // ---- Link side, clocked by the serial clock ----
    logic        link_rst_reg, link_rst_next;
    logic [3:0]  bcnt_reg, bcnt_next;
    logic [7:0]  shf_reg, shf_next;
    flrb_phase_t ph_reg, ph_next;
    logic        sel_reg, sel_next, rd_reg, rd_next;
    logic [7:0]  ptr_l_reg, ptr_l_next, dat_l_reg, dat_l_next;
    logic [2:0]  lv_reg, lv_next;        // Pointer, write, read request
    logic [7:0]  tx_reg, tx_next;
    logic        oe_reg, oe_next;
    logic [7:0]  rdb_reg, rdb_next;      // Read byte from system side
    logic        match;

    assign match = (shf_reg[7:1] == `FLRB_DEV_ADDR);

    // Receive shifter and byte phase, advanced on rising clock
    always_comb begin
        bcnt_next  = bcnt_reg;
        shf_next   = shf_reg;
        ph_next    = ph_reg;
        sel_next   = sel_reg;
        rd_next    = rd_reg;
        ptr_l_next = ptr_l_reg;
        dat_l_next = dat_l_reg;
        lv_next    = 3'h0;                // Levels last one clock period
        if (bcnt_reg != `FLRB_ACK_SLOT) begin
            shf_next  = {shf_reg[6:0], SDA_I}; // [R1]
            bcnt_next = bcnt_reg + 4'h1;
        end else begin
            bcnt_next = 4'h0;
            case (ph_reg)
                PH_ADDR: begin
                    sel_next  = match;    // [R15]
                    rd_next   = shf_reg[0];
                    lv_next[2] = match & shf_reg[0];
                    ph_next   = PH_REG;
                end
                PH_REG, PH_DATA: begin
                    if (rd_reg) begin
                        // Master ack asks for another byte, nack ends it
                        sel_next   = sel_reg & ~SDA_I;
                        lv_next[2] = sel_reg & ~SDA_I;
                    end else if (ph_reg == PH_REG) begin
                        ptr_l_next = shf_reg;  // [R15]
                        lv_next[0] = sel_reg;
                    end else begin
                        dat_l_next = shf_reg;
                        lv_next[1] = sel_reg;
                    end
                    ph_next = PH_DATA;
                end
                default: ph_next = PH_ADDR;
            endcase
        end
    end

    // Frame state; a start or stop clears it without the serial clock
    always_ff @(posedge SCL or posedge link_rst_reg) begin
        if (link_rst_reg) begin
            bcnt_reg  <= 4'h0;
            shf_reg   <= 8'h00;
            ph_reg    <= PH_ADDR;
            sel_reg   <= 1'b0;
            rd_reg    <= 1'b0;
            ptr_l_reg <= 8'h00;
            dat_l_reg <= 8'h00;
            lv_reg    <= 3'h0;
        end else begin
            bcnt_reg  <= bcnt_next;
            shf_reg   <= shf_next;
            ph_reg    <= ph_next;
            sel_reg   <= sel_next;
            rd_reg    <= rd_next;
            ptr_l_reg <= ptr_l_next;
            dat_l_reg <= dat_l_next;
            lv_reg    <= lv_next;
        end
    end

    // Data drive, changed only while the serial clock is low
    always_comb begin
        tx_next = (bcnt_reg == 4'h0) ? rdb_reg : {tx_reg[6:0], 1'b0};
        oe_next = (bcnt_reg == `FLRB_ACK_SLOT) &&
                  ((ph_reg == PH_ADDR) ? match : (sel_reg & ~rd_reg)); // [R3]
        if (sel_reg && rd_reg && bcnt_reg != `FLRB_ACK_SLOT)
            oe_next = ~tx_next[7];        // [R1]
    end

    always_ff @(negedge SCL or posedge link_rst_reg) begin
        if (link_rst_reg) begin
            tx_reg <= 8'h00;
            oe_reg <= 1'b0;
        end else begin
            tx_reg <= tx_next;
            oe_reg <= oe_next;
        end
    end

    assign SDA_O  = 1'b0;                 // Open drain, low only
    assign SDA_OE = oe_reg;

    // ---- System side ----
    localparam int NREG = 9;
    localparam logic [7:0] RST_VAL [0:NREG-1] = '{`FLRB_RST_MODE,
        `FLRB_RST_IND, `FLRB_RST_PIN, `FLRB_RST_SUP, `FLRB_RST_TORCH,
        `FLRB_RST_FLASH, `FLRB_RST_TOUT, `FLRB_RST_CFG1, `FLRB_RST_CFG2};

    logic [8:0]  s1_reg, s2_reg, d_reg;   // Pin synchronisers
    logic [2:0]  l1_reg, l2_reg, ld_reg;  // Link level synchronisers
    logic [7:0]  regs_reg [0:NREG-1];
    logic [7:0]  regs_next [0:NREG-1];
    logic [7:0]  flags_reg, flags_next, flag_set;
    logic [7:0]  ptr_reg, ptr_next, rd_val;
    logic [3:0]  ix;
    logic        p1_o_next, p1_oe_next, p2_o_next, p2_oe_next;
    logic        p1_o_reg, p1_oe_reg, p2_o_reg, p2_oe_reg;
    flrb_flash_t fl_reg, fl_next;
    logic [16:0] tmr_reg, tmr_next, dur;
    logic        scl_s, sda_s, trig_s, trig_rise, start_c, stop_c;
    logic        ptr_ev, wr_ev, rd_ev, expire, fl_end, int_act;

    assign scl_s     = s2_reg[8];
    assign sda_s     = s2_reg[7];
    assign trig_s    = s2_reg[6];
    assign trig_rise = trig_s & ~d_reg[6];
    assign start_c   = scl_s & d_reg[8] & d_reg[7] & ~sda_s;
    assign stop_c    = scl_s & d_reg[8] & ~d_reg[7] & sda_s;
    assign ptr_ev    = l2_reg[0] & ~ld_reg[0];
    assign wr_ev     = l2_reg[1] & ~ld_reg[1];
    assign rd_ev     = l2_reg[2] & ~ld_reg[2];
    assign int_act   = flags_reg[`FLRB_FL_THERM] | flags_reg[`FLRB_FL_SUP];

    // Offset to storage index; unmapped offsets read zero, ignore writes
    always_comb begin
        case (ptr_reg)
            `FLRB_OFS_MODE:  ix = `FLRB_IX_MODE;
            `FLRB_OFS_IND:   ix = `FLRB_IX_IND;
            `FLRB_OFS_PIN:   ix = `FLRB_IX_PIN;
            `FLRB_OFS_SUP:   ix = `FLRB_IX_SUP;
            `FLRB_OFS_TORCH: ix = `FLRB_IX_TORCH;
            `FLRB_OFS_FLASH: ix = `FLRB_IX_FLASH;
            `FLRB_OFS_TOUT:  ix = `FLRB_IX_TOUT;
            `FLRB_OFS_CFG1:  ix = `FLRB_IX_CFG1;
            `FLRB_OFS_CFG2:  ix = `FLRB_IX_CFG2;
            default:         ix = `FLRB_IX_NONE;
        endcase
    end

    // Read value; GPIO inputs show the live pin instead of stored data
    always_comb begin
        rd_val = 8'h00;
        if (ptr_reg == `FLRB_OFS_FLAGS)
            rd_val = flags_reg;
        else if (ix != `FLRB_IX_NONE)
            rd_val = regs_reg[ix];
        if (ix == `FLRB_IX_PIN) begin
            if (!regs_reg[`FLRB_IX_PIN][`FLRB_P1_DIR])
                rd_val[`FLRB_P1_DAT] = s2_reg[5];  // [R11]
            if (!regs_reg[`FLRB_IX_PIN][`FLRB_P2_DIR])
                rd_val[`FLRB_P2_DAT] = s2_reg[4];  // [R11]
        end
    end

    // Flash timer; duration grows with the timeout code
    assign dur    = 17'((17'({12'h000, regs_reg[`FLRB_IX_TOUT][`FLRB_TOUT_F]})
                    + 17'h00001) * 17'(TO_STEP_CYC));
    assign expire = (fl_reg == FL_ON) && (tmr_reg == dur - 17'h00001);
    assign fl_end = (fl_reg == FL_ON) && (expire ||
        (!regs_reg[`FLRB_IX_MODE][`FLRB_TRIG_MODE] && !trig_s)); // [R7]

    always_comb begin
        fl_next  = fl_reg;
        tmr_next = tmr_reg;
        case (fl_reg)
            FL_IDLE: begin
                tmr_next = 17'h00000;
                if (trig_rise)
                    fl_next = FL_ON;              // [R8]
            end
            FL_ON: begin
                tmr_next = tmr_reg + 17'h00001;
                if (fl_end)
                    fl_next = FL_IDLE;            // [R8]
            end
            default: fl_next = FL_IDLE;
        endcase
    end

    // Hardware flag sources; a set in the clearing read cycle survives
    always_comb begin
        flag_set = 8'h00;
        flag_set[`FLRB_FL_TO]    = expire;
        flag_set[`FLRB_FL_TSD]   = s2_reg[3];
        flag_set[`FLRB_FL_LEDF]  = s2_reg[2];
        flag_set[`FLRB_FL_THERM] = s2_reg[1];
        flag_set[`FLRB_FL_SUP]   = s2_reg[0] &
            regs_reg[`FLRB_IX_SUP][`FLRB_SUP_EN];  // [R12]
        flags_next = flags_reg;
        if (rd_ev && ptr_reg == `FLRB_OFS_FLAGS)
            flags_next = 8'h00;                   // [R16]
        if (fl_reg == FL_IDLE && trig_rise)
            flags_next[`FLRB_FL_TO] = 1'b0;       // New pulse clears timeout
        flags_next = flags_next | flag_set;
    end

    // Register writes; flash end clears the mode bits over any write
    always_comb begin
        ptr_next = ptr_ev ? ptr_l_reg : ptr_reg;
        for (int i = 0; i < NREG; i++) begin
            regs_next[i] = regs_reg[i];
            if (wr_ev && ix == 4'(i))
                regs_next[i] = dat_l_reg;
        end
        if (fl_end)
            regs_next[`FLRB_IX_MODE][`FLRB_MODE_F] = `FLRB_MODE_OFF; // [R6]
        rdb_next = rd_ev ? rd_val : rdb_reg;
    end

    // Multi purpose pin drive
    always_comb begin
        p1_oe_next = regs_reg[`FLRB_IX_PIN][`FLRB_P1_GPIO] &
                     regs_reg[`FLRB_IX_PIN][`FLRB_P1_DIR];    // [R10]
        p1_o_next  = regs_reg[`FLRB_IX_PIN][`FLRB_P1_DAT];    // [R11]
        p2_oe_next = regs_reg[`FLRB_IX_PIN][`FLRB_P2_GPIO] &
                     regs_reg[`FLRB_IX_PIN][`FLRB_P2_DIR];    // [R10]
        p2_o_next  = regs_reg[`FLRB_IX_PIN][`FLRB_P2_DAT];    // [R11]
        if (regs_reg[`FLRB_IX_PIN][`FLRB_P2_INT]) begin
            p2_o_next  = 1'b0;                                // [R14]
            p2_oe_next = p2_oe_next & int_act;                // [R14]
        end
    end

    // Start or stop holds the link logic in reset until the clock falls
    always_comb begin
        link_rst_next = link_rst_reg & scl_s;
        if (start_c || stop_c)
            link_rst_next = 1'b1;
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            s1_reg <= 9'h000; s2_reg <= 9'h000; d_reg <= 9'h000;
            l1_reg <= 3'h0; l2_reg <= 3'h0; ld_reg <= 3'h0;
            for (int i = 0; i < NREG; i++)
                regs_reg[i] <= RST_VAL[i];                    // [R4]
            flags_reg    <= `FLRB_RST_FLAGS;                  // [R4]
            ptr_reg      <= 8'h00;
            rdb_reg      <= 8'h00;
            fl_reg       <= FL_IDLE;
            tmr_reg      <= 17'h00000;
            link_rst_reg <= 1'b1;
            {p1_o_reg, p1_oe_reg, p2_o_reg, p2_oe_reg} <= 4'h0;
        end else begin
            s1_reg <= {SCL, SDA_I, FLASH_TRIG, FIRST_MPP_I, SECOND_MPP_I,
                       THERMAL_SD, LED_FAULT, LED_THERMAL_FLAG_IN,
                       SUPPLY_LOW};
            s2_reg <= s1_reg; d_reg <= s2_reg;
            l1_reg <= lv_reg; l2_reg <= l1_reg; ld_reg <= l2_reg;
            for (int i = 0; i < NREG; i++)
                regs_reg[i] <= regs_next[i];
            flags_reg    <= flags_next;
            ptr_reg      <= ptr_next;
            rdb_reg      <= rdb_next;
            fl_reg       <= fl_next;
            tmr_reg      <= tmr_next;
            link_rst_reg <= link_rst_next;
            {p1_o_reg, p1_oe_reg, p2_o_reg, p2_oe_reg} <=
                {p1_o_next, p1_oe_next, p2_o_next, p2_oe_next};
        end
    end

    assign FIRST_MPP_O   = p1_o_reg;
    assign FIRST_MPP_OE  = p1_oe_reg;
    assign SECOND_MPP_O  = p2_o_reg;
    assign SECOND_MPP_OE = p2_oe_reg;
    assign LED_MODE   = regs_reg[`FLRB_IX_MODE][`FLRB_MODE_F];   // [R5]
    assign FLASH_ON   = (fl_reg == FL_ON);
    assign IND_CODE   = regs_reg[`FLRB_IX_IND][`FLRB_CODE3_F];   // [R9]
    assign TORCH_CODE = regs_reg[`FLRB_IX_TORCH][`FLRB_CODE3_F];
    assign FLASH_CODE = regs_reg[`FLRB_IX_FLASH][`FLRB_CODE4_F];
    assign SUP_MON_EN = regs_reg[`FLRB_IX_SUP][`FLRB_SUP_EN];    // [R12]
    assign SUP_TH     = regs_reg[`FLRB_IX_SUP][`FLRB_SUP_TH_F];  // [R13]

    // Checks on the system clock, except the address ack check on the serial clock
    a_reset_defaults: assert property (@(posedge CLK) RESET |=>
        regs_reg[`FLRB_IX_MODE] == `FLRB_RST_MODE &&
        regs_reg[`FLRB_IX_CFG1] == `FLRB_RST_CFG1 && LED_MODE == 2'h0)
        else $error("Defaults not loaded");                 // [R4]
    a_mode_clear_end: assert property (@(posedge CLK) disable iff (RESET)
        $fell(FLASH_ON) |-> LED_MODE == `FLRB_MODE_OFF)
        else $error("Mode kept after flash");               // [R6]
    a_level_trig_end: assert property (@(posedge CLK) disable iff (RESET)
        FLASH_ON && !regs_reg[`FLRB_IX_MODE][`FLRB_TRIG_MODE] && !trig_s
        |=> !FLASH_ON) else $error("Level flash not ended"); // [R7]
    a_edge_trig_hold: assert property (@(posedge CLK) disable iff (RESET)
        FLASH_ON && regs_reg[`FLRB_IX_MODE][`FLRB_TRIG_MODE] && !expire
        |=> FLASH_ON) else $error("Edge flash ended early"); // [R8]
    a_flags_read_clr: assert property (@(posedge CLK) disable iff (RESET)
        rd_ev && ptr_reg == `FLRB_OFS_FLAGS && flag_set == 8'h00 |=>
        flags_reg == 8'h00 && rdb_reg == $past(flags_reg))
        else $error("Flags not cleared by read");           // [R16]
    a_gpio_one_out: assert property (@(posedge CLK) disable iff (RESET)
        regs_reg[`FLRB_IX_PIN][`FLRB_P1_GPIO] &&
        regs_reg[`FLRB_IX_PIN][`FLRB_P1_DIR] |=> FIRST_MPP_OE)
        else $error("Pin one not driven");                  // [R11]
    a_int_pull_low: assert property (@(posedge CLK) disable iff (RESET)
        SECOND_MPP_OE && $past(regs_reg[`FLRB_IX_PIN][`FLRB_P2_INT]) |->
        !SECOND_MPP_O && $past(int_act))
        else $error("Interrupt pin wrong");                 // [R14]
    a_sup_flag_off: assert property (@(posedge CLK) disable iff (RESET)
        !SUP_MON_EN |=> !$rose(flags_reg[`FLRB_FL_SUP]))
        else $error("Supply flag while off");               // [R12]
    a_ack_slot_low: assert property (@(posedge SCL) disable iff
        (link_rst_reg) bcnt_reg == `FLRB_ACK_SLOT && ph_reg == PH_ADDR &&
        match |-> SDA_OE) else $error("No address ack");    // [R3]
    c_edge_flash: cover property (@(posedge CLK)
        regs_reg[`FLRB_IX_MODE][`FLRB_TRIG_MODE] && expire);
    c_flags_read: cover property (@(posedge CLK)
        rd_ev && ptr_reg == `FLRB_OFS_FLAGS && flags_reg != 8'h00);
    c_reg_write: cover property (@(posedge CLK) wr_ev && ix != `FLRB_IX_NONE);
endmodule : flrb_reg_bank
